// ==== dv/adc_ready_cal_chk.sv ====
// Checker for the converter output stage, bound to its top module.
// Assumes one clock I_CLK and the active-high asynchronous reset I_RST.
module adc_ready_cal_chk (
    // Clock and reset
    input logic        I_CLK,
    input logic        I_RST,
    // Inputs watched
    input logic [3:0]  I_SAMPLE_VALID,
    input logic [3:0]  I_CH_HOLD,
    input logic        I_LINKED_READY_SELECT,
    input logic        I_GAIN_CORRECT_ENABLE,
    input logic [1:0]  I_PRESCALER,
    input logic [23:0] I_PHASE,
    input logic        I_EXTERNAL_CLOCK_SELECT,
    input logic        I_STATUS_RD,
    // Outputs watched
    input logic [3:0]  O_CHANNEL_READY_FLAGS,
    input logic [95:0] O_DATA,
    input logic        O_SAMPLE_READY_N,
    input logic        O_CRYSTAL_ENABLE,
    input logic        O_CLOCK_BYPASS,
    input logic        O_CRYSTAL_OUT_PULLDOWN,
    input logic        O_MODULATOR_TICK
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_RST);
    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    wire plain = !I_LINKED_READY_SELECT && !I_GAIN_CORRECT_ENABLE;
    wire lnk0  = !plain && !I_GAIN_CORRECT_ENABLE && I_PHASE == 24'h0 && I_CH_HOLD == 4'h0;
    sequence s_lag_ready;  lnk0 && I_SAMPLE_VALID == 4'h2; endsequence
    sequence s_lead_ready; lnk0 && I_SAMPLE_VALID == 4'h1; endsequence
    sequence s_gain_take;
        I_GAIN_CORRECT_ENABLE && !I_LINKED_READY_SELECT && I_SAMPLE_VALID == 4'h1 && !I_CH_HOLD[0];
    endsequence
    sequence s_tick_pre0; O_MODULATOR_TICK && I_PRESCALER == 2'h0; endsequence
    sequence s_tick_gap;  !O_MODULATOR_TICK [*3] ##1 O_MODULATOR_TICK; endsequence
    a_reset_values: assert property ($fell(I_RST) |-> O_CHANNEL_READY_FLAGS == 4'hF &&
        O_SAMPLE_READY_N && O_DATA == 96'h0) else $error("outputs wrong after reset");
    a_unlinked_pulse: assert property (plain && |(I_SAMPLE_VALID & ~I_CH_HOLD)
        |=> !O_SAMPLE_READY_N) else $error("no ready pulse for channel");
    a_own_flag: assert property (plain && I_SAMPLE_VALID[0] && !I_CH_HOLD[0]
        |=> !O_CHANNEL_READY_FLAGS[0]) else $error("flag not cleared on refresh");
    a_other_flags: assert property (plain && I_SAMPLE_VALID == 4'h1 && !I_STATUS_RD
        |=> $stable(O_CHANNEL_READY_FLAGS[3:1])) else $error("foreign flag changed");
    a_status_clear: assert property (I_STATUS_RD && I_SAMPLE_VALID == 4'h0
        && !I_GAIN_CORRECT_ENABLE && !O_MODULATOR_TICK
        |=> O_CHANNEL_READY_FLAGS == 4'hF) else $error("read did not set flags");
    a_linked_all: assert property (s_lag_ready |=> O_CHANNEL_READY_FLAGS == 4'h0
        && !O_SAMPLE_READY_N) else $error("linked update incomplete");
    a_linked_lead: assert property (s_lead_ready |=> O_SAMPLE_READY_N)
        else $error("leading channel pulsed in linked mode");
    a_crystal_on: assert property (!I_EXTERNAL_CLOCK_SELECT |=> O_CRYSTAL_ENABLE
        && !O_CLOCK_BYPASS && !O_CRYSTAL_OUT_PULLDOWN) else $error("crystal not enabled");
    a_crystal_bypass: assert property (I_EXTERNAL_CLOCK_SELECT |=> !O_CRYSTAL_ENABLE
        && O_CLOCK_BYPASS && O_CRYSTAL_OUT_PULLDOWN) else $error("crystal not bypassed");
    a_tick_period: assert property (s_tick_pre0 |=> s_tick_gap)
        else $error("modulator tick period wrong");
    a_gain_delay: assert property (s_gain_take |-> ##[89:103] !O_SAMPLE_READY_N)
        else $error("gain delayed pulse missing");
endmodule // adc_ready_cal_chk

// ==== dv/adc_ready_cal_tb.sv ====
// Self-checking bench for the converter output stage.
// Assumes the design, the checker and the host model are compiled first.
module adc_ready_cal_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        I_CLK = 1'b0;
    logic        I_RST = 1'b1;
    logic [95:0] I_SAMPLE = 96'h0;
    logic [3:0]  I_SAMPLE_VALID = 4'h0;
    logic [3:0]  I_CH_HOLD = 4'h0;
    logic        I_LINKED_READY_SELECT = 1'b0;
    logic        I_OFFSET_CORRECT_ENABLE = 1'b0;
    logic        I_GAIN_CORRECT_ENABLE = 1'b0;
    logic        I_FORMAT_24 = 1'b1;
    logic [2:0]  I_OVERSAMPLING_RATIO = 3'h3;
    logic [1:0]  I_PRESCALER = 2'h0;
    logic [23:0] I_PHASE = 24'h0;
    logic        I_EXTERNAL_CLOCK_SELECT = 1'b0;
    logic        I_CAL_WE = 1'b0;
    logic [2:0]  I_CAL_WADDR = 3'h0;
    logic [23:0] I_CAL_WDATA = 24'h0;
    logic [2:0]  I_CAL_RADDR = 3'h0;
    wire  [23:0] O_CAL_RDATA;
    wire         I_STATUS_RD;
    wire  [3:0]  O_CHANNEL_READY_FLAGS;
    wire  [95:0] O_DATA;
    wire         O_SAMPLE_READY_N, O_CRYSTAL_ENABLE, O_CLOCK_BYPASS;
    wire         O_CRYSTAL_OUT_PULLDOWN, O_MODULATOR_TICK;
    wire  [15:0] host_pulses;
    logic [76:0] rows [10];
    int          miscompares = 0;
    int          total_checks = 0;
    int          cnt;
    adc_ready_cal u_dut (.I_CLK, .I_RST, .I_SAMPLE, .I_SAMPLE_VALID, .I_CH_HOLD,
        .I_LINKED_READY_SELECT, .I_OFFSET_CORRECT_ENABLE, .I_GAIN_CORRECT_ENABLE,
        .I_FORMAT_24, .I_OVERSAMPLING_RATIO, .I_PRESCALER, .I_PHASE,
        .I_EXTERNAL_CLOCK_SELECT, .I_CAL_WE, .I_CAL_WADDR, .I_CAL_WDATA, .I_CAL_RADDR,
        .O_CAL_RDATA, .I_STATUS_RD, .O_CHANNEL_READY_FLAGS, .O_DATA, .O_SAMPLE_READY_N,
        .O_CRYSTAL_ENABLE, .O_CLOCK_BYPASS, .O_CRYSTAL_OUT_PULLDOWN, .O_MODULATOR_TICK);
    host_reader u_host (.i_clk(I_CLK), .i_rst(I_RST), .i_ready_n(O_SAMPLE_READY_N),
        .o_status_rd(I_STATUS_RD), .o_pulses(host_pulses));
    // ------------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------------
    task automatic check(input logic [99:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask
    task automatic close_out;
        $display("Checks %0d, mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge I_CLK);
    endtask
    task automatic wr_cal(input logic [2:0] a, input logic [23:0] d);
        @(posedge I_CLK);
        I_CAL_WE    <= 1'b1;
        I_CAL_WADDR <= a;
        I_CAL_WDATA <= d;
        @(posedge I_CLK);
        I_CAL_WE    <= 1'b0;
    endtask
    task automatic rd_cal(input logic [2:0] a, input logic [23:0] exp);
        @(posedge I_CLK);
        I_CAL_RADDR <= a;
        @(posedge I_CLK);
        #1;
        check(O_CAL_RDATA, exp);
    endtask
    // Result of a plain sample is settled one edge after its strobe
    task automatic send(input int ch, input logic [23:0] v);
        @(posedge I_CLK);
        I_SAMPLE[24*ch +: 24] <= v;
        I_SAMPLE_VALID        <= 4'h1 << ch;
        @(posedge I_CLK);
        I_SAMPLE_VALID        <= 4'h0;
        #1;
    endtask
    initial begin
        forever #5 I_CLK = ~I_CLK;
    end
    // Whole run needs under 2000 cycles; 100 us leaves ample margin
    initial begin
        #100000;
        miscompares++;
        close_out;
    end
    initial begin
        // Sample, offset word, offset on, 24-bit, ratio code, expected
        rows = '{{24'h000100, 24'h000010, 1'h0, 1'h1, 3'h3, 24'h000100},
                 {24'h000100, 24'h000010, 1'h1, 1'h1, 3'h3, 24'h000110},
                 {24'h000100, 24'h0000FF, 1'h1, 1'h1, 3'h0, 24'h000180},
                 {24'h000000, 24'h00001F, 1'h1, 1'h1, 3'h1, 24'h000010},
                 {24'h000000, 24'h000003, 1'h1, 1'h1, 3'h2, 24'h000002},
                 {24'h7FFFF0, 24'h000100, 1'h1, 1'h1, 3'h3, 24'h7FFFFF},
                 {24'h800010, 24'hFFFF00, 1'h1, 1'h1, 3'h3, 24'h800000},
                 {24'h123456, 24'h000000, 1'h0, 1'h0, 3'h3, 24'h001234},
                 {24'h7FFFF0, 24'h000100, 1'h1, 1'h0, 3'h3, 24'h007FFF},
                 {24'h800010, 24'hFFFF00, 1'h1, 1'h0, 3'h3, 24'h008000}};
        tick(10);
        I_RST <= 1'b0;
        tick(1);
        #1;
        check(O_CHANNEL_READY_FLAGS, 4'hF);
        check({O_SAMPLE_READY_N, O_CRYSTAL_ENABLE, O_DATA}, {2'h3, 96'h0});
        $display("Test reset done");
        foreach (rows[i]) begin
            wr_cal(3'h0, rows[i][52:29]);
            I_OFFSET_CORRECT_ENABLE <= rows[i][28];
            I_FORMAT_24             <= rows[i][27];
            I_OVERSAMPLING_RATIO    <= rows[i][26:24];
            send(0, rows[i][76:53]);
            check(O_DATA[23:0], rows[i][23:0]);
            check(O_CHANNEL_READY_FLAGS, 4'hE);
            check(O_SAMPLE_READY_N, 1'b0);
            tick(3);
            #1;
            check(O_CHANNEL_READY_FLAGS, 4'hF);
        end
        $display("Test calibration table done");
        @(posedge I_CLK);
        I_OFFSET_CORRECT_ENABLE <= 1'b0;
        I_FORMAT_24             <= 1'b1;
        rd_cal(3'h0, 24'hFFFF00);
        send(0, 24'h000100);
        check(O_DATA[23:0], 24'h000100);
        tick(3);
        I_LINKED_READY_SELECT <= 1'b1;
        send(0, 24'h0000AA);
        check({O_SAMPLE_READY_N, O_CHANNEL_READY_FLAGS}, 5'h1F);
        send(1, 24'h0000BB);
        check(O_DATA[47:0], 48'h0000BB0000AA);
        check({O_SAMPLE_READY_N, O_CHANNEL_READY_FLAGS}, 5'h00);
        tick(3);
        I_PHASE <= 24'h000005;
        send(1, 24'h0000CC);
        check(O_SAMPLE_READY_N, 1'b1);
        send(0, 24'h0000DD);
        check(O_DATA[47:0], 48'h0000CC0000DD);
        check(O_SAMPLE_READY_N, 1'b0);
        tick(3);
        I_PHASE               <= 24'h0;
        I_LINKED_READY_SELECT <= 1'b0;
        $display("Test linked ready done");
        wr_cal(3'h4, 24'h400000);
        I_GAIN_CORRECT_ENABLE <= 1'b1;
        send(0, 24'h000100);
        cnt = 0;
        while (O_SAMPLE_READY_N === 1'b1 && cnt < 200) begin
            @(posedge I_CLK);
            #1;
            cnt++;
        end
        check(cnt >= 88 && cnt <= 102, 1'b1);
        check(O_DATA[23:0], 24'h000180);
        tick(3);
        I_GAIN_CORRECT_ENABLE <= 1'b0;
        check(host_pulses, 16'h000E);
        $display("Test gain delay done");
        I_CH_HOLD               <= 4'h1;
        I_OFFSET_CORRECT_ENABLE <= 1'b1;
        send(0, 24'h000100);
        check({O_SAMPLE_READY_N, O_DATA[23:0]}, 25'h1000000);
        @(posedge I_CLK);
        I_CH_HOLD               <= 4'h0;
        I_EXTERNAL_CLOCK_SELECT <= 1'b1;
        tick(2);
        #1;
        check({O_CRYSTAL_ENABLE, O_CLOCK_BYPASS, O_CRYSTAL_OUT_PULLDOWN}, 3'h3);
        @(posedge I_CLK);
        I_EXTERNAL_CLOCK_SELECT <= 1'b0;
        tick(2);
        #1;
        check({O_CRYSTAL_ENABLE, O_CLOCK_BYPASS, O_CRYSTAL_OUT_PULLDOWN}, 3'h4);
        $display("Test hold and clock select done");
        send(2, 24'h000077);
        check(O_DATA[71:48], 24'h000077);
        @(posedge I_CLK);
        I_RST <= 1'b1;
        tick(2);
        #1;
        check({O_CHANNEL_READY_FLAGS, O_DATA}, {4'hF, 96'h0});
        @(posedge I_CLK);
        I_RST <= 1'b0;
        rd_cal(3'h4, 24'h000000);
        $display("Test second reset done");
        close_out;
    end
endmodule // adc_ready_cal_tb

bind adc_ready_cal adc_ready_cal_chk u_chk (.I_CLK, .I_RST, .I_SAMPLE_VALID, .I_CH_HOLD,
    .I_LINKED_READY_SELECT, .I_GAIN_CORRECT_ENABLE, .I_PRESCALER, .I_PHASE, .I_STATUS_RD,
    .I_EXTERNAL_CLOCK_SELECT, .O_DATA, .O_CHANNEL_READY_FLAGS, .O_SAMPLE_READY_N,
    .O_CRYSTAL_ENABLE, .O_CLOCK_BYPASS, .O_CRYSTAL_OUT_PULLDOWN, .O_MODULATOR_TICK);

// ==== dv/host_reader.sv ====
// Host model: answers each data-ready pulse with one status read.
// Assumes the active-low ready pin and the one-cycle status read of the stage.
module host_reader (
    // Clock and reset
    input  logic        i_clk,
    input  logic        i_rst,
    // Device side
    input  logic        i_ready_n,
    output logic        o_status_rd,
    output logic [15:0] o_pulses
);
    timeunit 1ns;
    timeprecision 1ps;
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_status_rd <= 1'b0;
            o_pulses    <= 16'h0000;
        end else begin
            o_status_rd <= !i_ready_n;
            o_pulses    <= o_pulses + {15'h0000, !i_ready_n};
        end
    end
endmodule // host_reader

// ==== rtl/adc_cal_regs.vh ====
// Constants for the converter output stage: calibration, ready logic, datapath, timing.
// Assumes one 100 MHz master clock and a register map held outside this block.
`ifndef ADC_CAL_REGS_VH
`define ADC_CAL_REGS_VH

// ----------------------------------------------------------------------------
// Calibration word store
// ----------------------------------------------------------------------------
`define CAL_SEL_OFFSET      1'h0
`define CAL_SEL_GAIN        1'h1
`define CAL_WORD_RESET      24'h000000

// ----------------------------------------------------------------------------
// Ready status
// ----------------------------------------------------------------------------
`define READY_FLAGS_RESET   4'hF
`define LINKED_READY_RESET  1'h1

// ----------------------------------------------------------------------------
// Datapath
// ----------------------------------------------------------------------------
`define GAIN_UNITY          25'h0800000
`define GAIN_SHIFT          23
`define FULL24_POS          24'h7FFFFF
`define FULL24_NEG          24'h800000
`define FULL16_POS          16'h7FFF
`define FULL16_NEG          16'h8000
`define OSR_CODE_32         3'h0
`define OSR_CODE_64         3'h1
`define OSR_CODE_128        3'h2
`define OFFSET_MASK_OSR32   24'hFFFF80
`define OFFSET_MASK_OSR64   24'hFFFFF0
`define OFFSET_MASK_OSR128  24'hFFFFFE
`define OFFSET_MASK_FULL    24'hFFFFFF

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define GAIN_DELAY_MODULATOR_CLOCK    5'h18
`define MODULATOR_CLOCK_BASE_DIV      6'h04
`define PHASE_SIGN_MAX      4'h7

`endif

// ==== rtl/adc_ready_cal.v ====
// Output stage of a four-channel converter: calibration, data-ready pin and
// ready flags, master clock source select.
// Assumes samples and their strobes come from filters on I_CLK, and the
// configuration bits from a register map on the same clock.
//
// What this block does
// - Unlinked: every enabled channel pulses ready pin
// - Linked (default): only most lagging channel pulses
// - Linked: all active outputs latched together
// - Lag from phase and oversampling settings
// - Four ready flags readable at any time
// - Writes to ready flags have no effect
// - Ready flags reset to one
// - Flag goes zero when output refreshes
// - Status read returns all flags to one; a refresh in the same cycle still clears its flags
// - Linked: all flags update with ready pulse
// - Unlinked: each flag updates with its channel
// - External select zero enables crystal oscillator
// - External select one bypasses crystal, buffers input
// - One offset enable, one gain enable
// - Offset word added to output code
// - Offset addition adds no latency
// - Low oversampling adds only significant offset bits
// - No correction on held or shut channels
// - Disabling correction keeps stored words
// - Multiply by one plus signed gain
// - Gain enable delays outputs 24 modulator clocks
// - Clamp results to full scale
// - Hard reset zeroes outputs and defaults
`include "adc_cal_regs.vh"

module adc_ready_cal (
    // Clock and reset
    input  wire         I_CLK,
    input  wire         I_RST,
    // Samples from the decimation filters, channel n at [24*n +: 24]
    input  wire [95:0]  I_SAMPLE,
    input  wire [3:0]   I_SAMPLE_VALID,
    // Per-channel reset or shutdown
    input  wire [3:0]   I_CH_HOLD,
    // Configuration
    input  wire         I_LINKED_READY_SELECT,
    input  wire         I_OFFSET_CORRECT_ENABLE,
    input  wire         I_GAIN_CORRECT_ENABLE,
    input  wire         I_FORMAT_24,
    input  wire [2:0]   I_OVERSAMPLING_RATIO,
    input  wire [1:0]   I_PRESCALER,
    input  wire [23:0]  I_PHASE,
    input  wire         I_EXTERNAL_CLOCK_SELECT,
    // Calibration word access, address = {gain/offset, channel[1:0]}
    input  wire         I_CAL_WE,
    input  wire [2:0]   I_CAL_WADDR,
    input  wire [23:0]  I_CAL_WDATA,
    input  wire [2:0]   I_CAL_RADDR,
    output wire [23:0]  O_CAL_RDATA,
    // Status register read
    input  wire         I_STATUS_RD,
    output wire [3:0]   O_CHANNEL_READY_FLAGS,
    // Corrected channel data, channel n at [24*n +: 24]
    output wire [95:0]  O_DATA,
    // Data-ready pin, active low pulse
    output reg          O_SAMPLE_READY_N,
    // Clock source control
    output reg          O_CRYSTAL_ENABLE,
    output reg          O_CLOCK_BYPASS,
    output reg          O_CRYSTAL_OUT_PULLDOWN,
    // Modulator clock enable pulse
    output reg          O_MODULATOR_TICK
);

    // ------------------------------------------------------------------------
    // Calibration words
    // ------------------------------------------------------------------------
    wire [191:0] cal_words;

    cal_word_store u_store (
        .clk     (I_CLK),
        .rst     (I_RST),
        .i_we    (I_CAL_WE),
        .i_waddr (I_CAL_WADDR),
        .i_wdata (I_CAL_WDATA),
        .i_raddr (I_CAL_RADDR),
        .o_rdata (O_CAL_RDATA),
        .o_words (cal_words)
    );

    // ------------------------------------------------------------------------
    // Modulator clock divider
    // ------------------------------------------------------------------------
    reg  [5:0] div_cnt;
    wire [5:0] div_last;

    assign div_last = (`MODULATOR_CLOCK_BASE_DIV << I_PRESCALER) - 6'h01;

    always @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            div_cnt          <= 6'h00;
            O_MODULATOR_TICK <= 1'b0;
        end else if (div_cnt >= div_last) begin
            div_cnt          <= 6'h00;
            O_MODULATOR_TICK <= 1'b1;
        end else begin
            div_cnt          <= div_cnt + 6'h01;
            O_MODULATOR_TICK <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // Offset resolution by oversampling ratio
    // ------------------------------------------------------------------------
    reg [23:0] offset_mask;

    always @* begin
        case (I_OVERSAMPLING_RATIO)
            `OSR_CODE_32:  offset_mask = `OFFSET_MASK_OSR32;
            `OSR_CODE_64:  offset_mask = `OFFSET_MASK_OSR64;
            `OSR_CODE_128: offset_mask = `OFFSET_MASK_OSR128;
            default:       offset_mask = `OFFSET_MASK_FULL;
        endcase
    end

    // ------------------------------------------------------------------------
    // Most lagging active channel
    // ------------------------------------------------------------------------
    wire [3:0]        sign_shift;
    wire signed [11:0] phase_a;
    wire signed [11:0] phase_b;
    reg  signed [11:0] lag_value [0:3];
    reg  signed [11:0] best_lag;
    reg  [1:0]         lag_ch;
    integer            c;

    assign sign_shift = `PHASE_SIGN_MAX - {1'b0, I_OVERSAMPLING_RATIO};
    // Phase code width follows the oversampling ratio
    assign phase_a = $signed(I_PHASE[11:0] << sign_shift) >>> sign_shift;
    assign phase_b = $signed(I_PHASE[23:12] << sign_shift) >>> sign_shift;

    always @* begin
        lag_value[0] = phase_a;
        lag_value[1] = 12'sh000;
        lag_value[2] = phase_b;
        lag_value[3] = 12'sh000;
        best_lag     = 12'sh800;
        lag_ch       = 2'h1;
        // Odd channels are the time reference and win ties
        for (c = 3; c >= 0; c = c - 1) begin
            if (!I_CH_HOLD[c] && ((lag_value[c] > best_lag)
                    || (c[0] && (lag_value[c] == best_lag)))) begin
                best_lag = lag_value[c];
                lag_ch   = c[1:0];
            end
        end
    end

    // ------------------------------------------------------------------------
    // Per-channel correction and gain delay
    // ------------------------------------------------------------------------
    wire [95:0] corrected;
    wire [95:0] refresh_data;
    wire [3:0]  refresh;
    reg  [95:0] staged;
    reg  [95:0] pending;
    reg  [19:0] delay_cnt;

    genvar n;
    generate
        for (n = 0; n < 4; n = n + 1) begin : g_ch
            wire direct;
            wire delayed;

            // Words stay stored whatever the enables do
            cal_datapath u_cal (
                .i_sample      (I_SAMPLE[24*n +: 24]),
                .i_offset      (cal_words[24*n +: 24]),
                .i_gain        (cal_words[24*(n+4) +: 24]),
                .i_offset_mask (offset_mask),
                .i_offset_en   (I_OFFSET_CORRECT_ENABLE),
                .i_gain_en     (I_GAIN_CORRECT_ENABLE),
                .i_hold        (I_CH_HOLD[n]),
                .i_fmt24       (I_FORMAT_24),
                .o_result      (corrected[24*n +: 24])
            );

            assign direct  = I_SAMPLE_VALID[n] && !I_GAIN_CORRECT_ENABLE;
            assign delayed = O_MODULATOR_TICK && (delay_cnt[5*n +: 5] == 5'h01);
            assign refresh[n] = direct || delayed;
            assign refresh_data[24*n +: 24] = direct ? corrected[24*n +: 24]
                                                     : pending[24*n +: 24];

            always @(posedge I_CLK or posedge I_RST) begin
                if (I_RST) begin
                    pending[24*n +: 24] <= 24'h000000;
                    delay_cnt[5*n +: 5] <= 5'h00;
                    staged[24*n +: 24]  <= 24'h000000;
                end else begin
                    if (I_SAMPLE_VALID[n] && I_GAIN_CORRECT_ENABLE) begin
                        pending[24*n +: 24] <= corrected[24*n +: 24];
                        delay_cnt[5*n +: 5] <= `GAIN_DELAY_MODULATOR_CLOCK;
                    end else if (O_MODULATOR_TICK && (delay_cnt[5*n +: 5] != 5'h00)) begin
                        delay_cnt[5*n +: 5] <= delay_cnt[5*n +: 5] - 5'h01;
                    end
                    if (refresh[n]) begin
                        staged[24*n +: 24] <= refresh_data[24*n +: 24];
                    end
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------------
    // Output latching, ready pin and ready flags
    // ------------------------------------------------------------------------
    reg  [95:0] out_data;
    reg  [3:0]  ready_flags;
    reg  [95:0] next_out_data;
    reg  [3:0]  next_flags;
    reg         next_pulse;
    integer     m;

    always @* begin
        next_out_data = out_data;
        next_flags    = ready_flags;
        next_pulse    = 1'b0;
        if (I_STATUS_RD) begin
            next_flags = `READY_FLAGS_RESET;
        end
        if (I_LINKED_READY_SELECT) begin
            if (refresh[lag_ch] && !I_CH_HOLD[lag_ch]) begin
                next_pulse = 1'b1;
                next_flags = 4'h0;
                for (m = 0; m < 4; m = m + 1) begin
                    if (m == lag_ch) begin
                        next_out_data[24*m +: 24] = refresh_data[24*m +: 24];
                    end else if (refresh[m]) begin
                        next_out_data[24*m +: 24] = refresh_data[24*m +: 24];
                    end else begin
                        next_out_data[24*m +: 24] = staged[24*m +: 24];
                    end
                end
            end
        end else begin
            for (m = 0; m < 4; m = m + 1) begin
                if (refresh[m]) begin
                    next_out_data[24*m +: 24] = refresh_data[24*m +: 24];
                    next_flags[m] = 1'b0;
                    if (!I_CH_HOLD[m]) begin
                        next_pulse = 1'b1;
                    end
                end
            end
        end
        for (m = 0; m < 4; m = m + 1) begin
            if (I_CH_HOLD[m]) begin
                next_out_data[24*m +: 24] = 24'h000000;
            end
        end
    end

    // Flags have no write path at all, so host writes cannot reach them
    always @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            out_data         <= 96'h0;
            ready_flags      <= `READY_FLAGS_RESET;
            O_SAMPLE_READY_N <= 1'b1;
        end else begin
            out_data         <= next_out_data;
            ready_flags      <= next_flags;
            O_SAMPLE_READY_N <= ~next_pulse;
        end
    end

    assign O_DATA                = out_data;
    assign O_CHANNEL_READY_FLAGS = ready_flags;

    // ------------------------------------------------------------------------
    // Master clock source select
    // ------------------------------------------------------------------------
    always @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            O_CRYSTAL_ENABLE       <= 1'b1;
            O_CLOCK_BYPASS         <= 1'b0;
            O_CRYSTAL_OUT_PULLDOWN <= 1'b0;
        end else begin
            O_CRYSTAL_ENABLE       <= !I_EXTERNAL_CLOCK_SELECT;
            O_CLOCK_BYPASS         <= I_EXTERNAL_CLOCK_SELECT;
            O_CRYSTAL_OUT_PULLDOWN <= I_EXTERNAL_CLOCK_SELECT;
        end
    end

endmodule // adc_ready_cal

// ==== rtl/cal_datapath.v ====
// Offset add, gain multiply and full-scale clamp for one channel.
// Purely combinational; the caller registers the result.
`include "adc_cal_regs.vh"

module cal_datapath (
    // Sample and words
    input  wire [23:0] i_sample,
    input  wire [23:0] i_offset,
    input  wire [23:0] i_gain,
    // Controls
    input  wire [23:0] i_offset_mask,
    input  wire        i_offset_en,
    input  wire        i_gain_en,
    input  wire        i_hold,
    input  wire        i_fmt24,
    // Result
    output reg  [23:0] o_result
);

    reg signed [24:0] sum;
    reg signed [24:0] factor;
    reg signed [49:0] product;
    reg signed [49:0] scaled;

    always @* begin
        sum     = $signed({i_sample[23], i_sample});
        factor  = $signed(`GAIN_UNITY);
        if (i_offset_en && !i_hold) begin
            sum = sum + $signed({i_offset[23], i_offset & i_offset_mask});
        end
        if (i_gain_en && !i_hold) begin
            factor = $signed(`GAIN_UNITY) + $signed({i_gain[23], i_gain});
        end
        product = sum * factor;
        scaled  = product >>> `GAIN_SHIFT;
        o_result = 24'h000000;
        if (i_fmt24) begin
            if (scaled > $signed({{26{1'b0}}, `FULL24_POS})) begin
                o_result = `FULL24_POS;
            end else if (scaled < $signed({{26{1'b1}}, `FULL24_NEG})) begin
                o_result = `FULL24_NEG;
            end else begin
                o_result = scaled[23:0];
            end
        end else begin
            scaled = scaled >>> 8;
            if (scaled > $signed({{34{1'b0}}, `FULL16_POS})) begin
                o_result = {8'h00, `FULL16_POS};
            end else if (scaled < $signed({{34{1'b1}}, `FULL16_NEG})) begin
                o_result = {8'h00, `FULL16_NEG};
            end else begin
                o_result = {8'h00, scaled[15:0]};
            end
        end
    end

endmodule // cal_datapath

// ==== rtl/cal_word_store.v ====
// Per-channel offset and gain words, eight 24-bit entries.
// Written by the register map; all words visible at once, host read registered.
`include "adc_cal_regs.vh"

module cal_word_store (
    // Clock and reset
    input  wire         clk,
    input  wire         rst,
    // Write port
    input  wire         i_we,
    input  wire [2:0]   i_waddr,
    input  wire [23:0]  i_wdata,
    // Read port
    input  wire [2:0]   i_raddr,
    output reg  [23:0]  o_rdata,
    // All words: entry k at [24*k +: 24], k = {sel, channel}
    output wire [191:0] o_words
);

    reg [23:0] mem [0:7];

    genvar k;
    generate
        for (k = 0; k < 8; k = k + 1) begin : g_word
            always @(posedge clk or posedge rst) begin
                if (rst) begin
                    mem[k] <= `CAL_WORD_RESET;
                end else if (i_we && (i_waddr == k)) begin
                    mem[k] <= i_wdata;
                end
            end
            assign o_words[24*k +: 24] = mem[k];
        end
    endgenerate

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            o_rdata <= `CAL_WORD_RESET;
        end else begin
            o_rdata <= mem[i_raddr];
        end
    end

endmodule // cal_word_store
